// ==== logic/cfg_status_pkg.sv ====
package cfg_status_pkg;

   // Configuration space byte offsets
   localparam logic [11:0] STATUS_OFS      = 12'h006;
   localparam logic [11:0] REVISION_OFS    = 12'h008;

   // Dword index of each register and its byte lane position
   localparam logic [9:0]  STATUS_DW       = STATUS_OFS[11:2];
   localparam logic [9:0]  REVISION_DW     = REVISION_OFS[11:2];
   localparam int unsigned STATUS_SHIFT    = 8 * int'(STATUS_OFS[1:0]);
   localparam int unsigned REVISION_SHIFT  = 8 * int'(REVISION_OFS[1:0]);

   // Status register layout
   localparam int unsigned STATUS_WIDTH    = 16;
   localparam logic [15:0] STATUS_RST      = 16'h0010;
   localparam int unsigned POISON_SEEN_BIT = 15;
   localparam int unsigned SYS_ERR_BIT     = 14;
   localparam int unsigned UNSUP_CPL_BIT   = 13;
   localparam int unsigned ABORT_CPL_BIT   = 12;
   localparam int unsigned SENT_ABORT_BIT  = 11;
   localparam int unsigned REQ_POISON_BIT  = 8;
   localparam int unsigned CAP_LIST_BIT    = 4;

   // Hardwired read-only fields
   localparam logic [1:0]  SELECT_TIMING   = 2'h0;
   localparam logic        B2B_CAPABLE     = 1'h0;
   localparam logic        SPEED66_CAPABLE = 1'h0;
   localparam logic        CAP_LIST        = 1'h1;
   localparam logic        LEGACY_IRQ      = 1'h0;

   // Sticky flag slots in the flag bank
   localparam int unsigned NUM_FLAGS       = 6;
   localparam int unsigned FLG_REQ_POISON  = 0;
   localparam int unsigned FLG_SENT_ABORT  = 1;
   localparam int unsigned FLG_ABORT_CPL   = 2;
   localparam int unsigned FLG_UNSUP_CPL   = 3;
   localparam int unsigned FLG_SYS_ERR     = 4;
   localparam int unsigned FLG_POISON_SEEN = 5;
   localparam int unsigned FLAG_POS [NUM_FLAGS] = '{
      REQ_POISON_BIT, SENT_ABORT_BIT, ABORT_CPL_BIT,
      UNSUP_CPL_BIT, SYS_ERR_BIT, POISON_SEEN_BIT
   };

   // Revision value, arbitrary
   localparam logic [7:0]  REVISION_DEFAULT = 8'h5A;

endpackage : cfg_status_pkg

// ==== logic/sticky_flag_bank.sv ====
`timescale 1ns/10ps
module sticky_flag_bank #(
   parameter int unsigned N = 6
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         reset_n_i,
   // Hardware set and software clear
   input  wire logic [N-1:0] set_i,
   input  wire logic [N-1:0] clr_i,
   // Flag state
   output logic      [N-1:0] flags_o
);

   typedef struct packed {
      logic [N-1:0] flags;
   } bank_s;

   bank_s state_ff;
   bank_s nxt_state;

   always_comb begin
      nxt_state = state_ff;
      // Set wins so an event landing on a clear is kept
      nxt_state.flags = (state_ff.flags & ~clr_i) | set_i; // see RULE16 see RULE7
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= '0; // see RULE7
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flags_o = state_ff.flags;

endmodule : sticky_flag_bank

// ==== logic/pcie_config_status_bits.sv ====
// How it works
// RULE1 - A poisoned packet received sets poison_seen_flag at bit 15 with no enable needed.
// RULE2 - Sending a fatal or non-fatal error message sets sys_err_sent_flag at bit 14 if enabled.
// RULE3 - A completion with Unsupported Request status sets got_unsupported_cpl_flag at bit 13.
// RULE4 - A completion received with Completer Abort status sets got_abort_cpl_flag at bit 12.
// RULE5 - Finishing a request as completer with Completer Abort sets sent_abort_flag at bit 11.
// RULE6 - A poisoned completion in or poisoned request out sets bit 8 if parity response is on.
// RULE7 - The event flags reset to zero, clear on a written one and ignore a written zero.
// RULE8 - The select timing field at bits 10 to 9 reads 00b and ignores writes.
// RULE9 - The back-to-back bit 7 and the 66 MHz bit 5 are read-only zero.
// RULE10 - The capability list bit 4 is read-only one.
// RULE11 - The legacy interrupt pending bit 3 is read-only zero.
// RULE12 - The status register is 16 bits at offset 0x6; reserved bits 6 and 2 to 0 read zero.
// RULE13 - An 8-bit read-only revision value sits at offset 0x8.
// RULE14 - Software sets command bit 6 to let poisoned traffic be logged in bit 8.
// RULE15 - Software sets command bit 8 to allow error reporting toward the root complex.
// RULE16 - When a set and a clear hit one flag in the same cycle, the set wins.
`timescale 1ns/10ps
module pcie_config_status_bits #(
   parameter logic [7:0] REVISION_VALUE = cfg_status_pkg::REVISION_DEFAULT
) (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   // Configuration access, dword address with byte enables
   input  wire logic        cfg_rd_i,
   input  wire logic        cfg_wr_i,
   input  wire logic [9:0]  cfg_dw_addr_i,
   input  wire logic [3:0]  cfg_be_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic      [31:0] cfg_rdata_o,
   output logic             cfg_rvalid_o,
   // Command register enables
   input  wire logic        poison_response_enable_i,
   input  wire logic        sys_err_report_enable_i,
   // Transaction layer events, one-cycle pulses
   input  wire logic        poison_tlp_rx_i,
   input  wire logic        poison_cpl_rx_i,
   input  wire logic        poison_req_tx_i,
   input  wire logic        err_msg_tx_i,
   input  wire logic        cpl_ur_rx_i,
   input  wire logic        cpl_ca_rx_i,
   input  wire logic        ca_cpl_tx_i,
   // Register views
   output logic      [15:0] link_event_status_o,
   output logic      [7:0]  silicon_revision_value_o
);

   typedef struct packed {
      logic [31:0] rdata;
      logic        rvalid;
   } port_s;

   port_s state_ff;
   port_s nxt_state;

   logic [cfg_status_pkg::NUM_FLAGS-1:0] flag_set;
   logic [cfg_status_pkg::NUM_FLAGS-1:0] flag_clr;
   logic [cfg_status_pkg::NUM_FLAGS-1:0] flags;
   logic [15:0]                          status_word;
   logic                                 status_wr;

   // Event sources into the flag slots
   always_comb begin
      flag_set = '0;
      flag_set[cfg_status_pkg::FLG_POISON_SEEN] = poison_tlp_rx_i; // see RULE1
      flag_set[cfg_status_pkg::FLG_SYS_ERR] =
         err_msg_tx_i & sys_err_report_enable_i; // see RULE2 see RULE15
      flag_set[cfg_status_pkg::FLG_UNSUP_CPL] = cpl_ur_rx_i; // see RULE3
      flag_set[cfg_status_pkg::FLG_ABORT_CPL] = cpl_ca_rx_i; // see RULE4
      flag_set[cfg_status_pkg::FLG_SENT_ABORT] = ca_cpl_tx_i; // see RULE5
      flag_set[cfg_status_pkg::FLG_REQ_POISON] = poison_response_enable_i
         & (poison_cpl_rx_i | poison_req_tx_i); // see RULE6 see RULE14
   end

   assign status_wr = cfg_wr_i && (cfg_dw_addr_i == cfg_status_pkg::STATUS_DW);

   // Write-one clear per flag, gated by the byte lane holding that flag
   for (genvar g = 0; g < cfg_status_pkg::NUM_FLAGS; g++) begin : g_clr
      localparam int unsigned DW_BIT =
         cfg_status_pkg::FLAG_POS[g] + cfg_status_pkg::STATUS_SHIFT;
      assign flag_clr[g] = status_wr & cfg_be_i[DW_BIT/8] & cfg_wdata_i[DW_BIT]; // see RULE7
   end

   sticky_flag_bank #(
      .N (cfg_status_pkg::NUM_FLAGS)
   ) u_flags (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (flag_set),
      .clr_i     (flag_clr),
      .flags_o   (flags)
   );

   // Status assembly; hardwired fields take no write path at all
   always_comb begin
      status_word = '0; // see RULE12
      status_word[10:9] = cfg_status_pkg::SELECT_TIMING; // see RULE8
      status_word[7] = cfg_status_pkg::B2B_CAPABLE; // see RULE9
      status_word[5] = cfg_status_pkg::SPEED66_CAPABLE; // see RULE9
      status_word[cfg_status_pkg::CAP_LIST_BIT] = cfg_status_pkg::CAP_LIST; // see RULE10
      status_word[3] = cfg_status_pkg::LEGACY_IRQ; // see RULE11
      for (int i = 0; i < int'(cfg_status_pkg::NUM_FLAGS); i++) begin
         status_word[cfg_status_pkg::FLAG_POS[i]] = flags[i];
      end
   end

   // Read decode; offsets outside this block read zero
   function automatic logic [31:0] cfg_read(input logic [9:0]  dw,
                                            input logic [15:0] sts,
                                            input logic [7:0]  rev);
      logic [31:0] data;
      data = '0;
      if (dw == cfg_status_pkg::STATUS_DW) begin
         data = 32'(sts) << cfg_status_pkg::STATUS_SHIFT; // see RULE12
      end else if (dw == cfg_status_pkg::REVISION_DW) begin
         data = 32'(rev) << cfg_status_pkg::REVISION_SHIFT; // see RULE13
      end
      return data;
   endfunction : cfg_read

   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = cfg_rd_i;
      if (cfg_rd_i) begin
         // Read shows the value before any clear in the same cycle
         nxt_state.rdata = cfg_read(cfg_dw_addr_i, status_word, REVISION_VALUE);
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign cfg_rdata_o              = state_ff.rdata;
   assign cfg_rvalid_o             = state_ff.rvalid;
   assign link_event_status_o      = status_word;
   assign silicon_revision_value_o = REVISION_VALUE; // see RULE13

endmodule : pcie_config_status_bits

// ==== sim/cfg_status_props.sv ====
`timescale 1ns/10ps
module cfg_status_props (
   // Clock and requests
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic        cfg_wr_i,
   input wire logic [9:0]  cfg_dw_addr_i,
   input wire logic [3:0]  cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   // Enables and events
   input wire logic        poison_response_enable_i,
   input wire logic        sys_err_report_enable_i,
   input wire logic        poison_tlp_rx_i,
   input wire logic        poison_cpl_rx_i,
   input wire logic        poison_req_tx_i,
   input wire logic        err_msg_tx_i,
   input wire logic        cpl_ur_rx_i,
   input wire logic        cpl_ca_rx_i,
   input wire logic        ca_cpl_tx_i,
   // Register view
   input wire logic [15:0] link_event_status_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic clr15 = cfg_wr_i && cfg_dw_addr_i == 10'h001 && cfg_be_i[3] && cfg_wdata_i[31];
   a_poison_set: assert property (poison_tlp_rx_i |=> link_event_status_o[15])
      else $error("poison flag not set");
   a_sys_err_cause: assert property ($rose(link_event_status_o[14]) |->
      $past(err_msg_tx_i && sys_err_report_enable_i)) else $error("system error flag rose alone");
   a_unsup_set: assert property (cpl_ur_rx_i |=> link_event_status_o[13])
      else $error("unsupported completion flag not set");
   a_abort_set: assert property (cpl_ca_rx_i |=> link_event_status_o[12])
      else $error("abort completion flag not set");
   a_sent_abort: assert property (ca_cpl_tx_i |=> link_event_status_o[11])
      else $error("sent abort flag not set");
   a_parity_gate: assert property ($rose(link_event_status_o[8]) |->
      $past(poison_response_enable_i && (poison_cpl_rx_i || poison_req_tx_i)))
      else $error("requester poison flag rose alone");
   a_clear_one: assert property (
      clr15 && !poison_tlp_rx_i |=> !link_event_status_o[15])
      else $error("written one did not clear");
   a_zero_keeps: assert property (
      link_event_status_o[15] && !clr15 |=> link_event_status_o[15])
      else $error("flag lost without a clear");
   a_fixed_bits: assert property (
      (link_event_status_o & 16'h06FF) == 16'h0010)
      else $error("hardwired status bits wrong");
   a_sys_err_set: assert property (
      err_msg_tx_i && sys_err_report_enable_i |=> link_event_status_o[14])
      else $error("system error flag not set");
   a_req_poison_set: assert property (
      poison_response_enable_i && (poison_cpl_rx_i || poison_req_tx_i) |=> link_event_status_o[8])
      else $error("requester poison flag not set");
endmodule : cfg_status_props
bind pcie_config_status_bits cfg_status_props u_props (.*);

// ==== sim/cfg_sw_model.sv ====
`timescale 1ns/10ps
module cfg_sw_model (
   // Config access toward the device
   output logic        rd_o,
   output logic        wr_o,
   output logic [9:0]  addr_o,
   output logic [3:0]  be_o,
   output logic [31:0] wdata_o,
   // Command register enables
   output logic        poison_response_enable_o,
   output logic        sys_err_report_enable_o
);
   initial {rd_o, wr_o, addr_o, be_o, wdata_o} = '0;
   initial {poison_response_enable_o, sys_err_report_enable_o} = 2'h0;
   // One access per call; caller paces calls one clock apart
   task automatic drive(input logic rd, wr, input logic [9:0] a, input logic [3:0] be,
                        input logic [31:0] d, input logic pre, sys_err_report_enable);
      {rd_o, wr_o, addr_o, be_o} = {rd, wr, a, be};
      // Idle data flips to the complement of its previous value on each call
      wdata_o = wr ? d : ~wdata_o;
      poison_response_enable_o = pre;
      sys_err_report_enable_o = sys_err_report_enable;
   endtask : drive
endmodule : cfg_sw_model

// ==== sim/pcie_config_status_bits_tb.sv ====
`timescale 1ns/10ps
module pcie_config_status_bits_tb;
   logic        ref_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        cfg_rd_i, cfg_wr_i, poison_response_enable_i, sys_err_report_enable_i;
   logic [9:0]  cfg_dw_addr_i;
   logic [3:0]  cfg_be_i;
   logic [31:0] cfg_wdata_i, cfg_rdata_o, r, w, erd;
   logic        cfg_rvalid_o, rd;
   logic [15:0] link_event_status_o, m, clr, set;
   logic [7:0]  silicon_revision_value_o;
   logic [6:0]  ev = 7'h00;
   wire logic   poison_tlp_rx_i, err_msg_tx_i, cpl_ur_rx_i, cpl_ca_rx_i, ca_cpl_tx_i;
   wire logic   poison_cpl_rx_i, poison_req_tx_i;
   integer      seed = 32'h9A4D;
   int          errors = 0;
   int          check_count = 0;
   int          cycles = 0;
   assign {poison_req_tx_i, poison_cpl_rx_i, ca_cpl_tx_i, cpl_ca_rx_i, cpl_ur_rx_i,
           err_msg_tx_i, poison_tlp_rx_i} = ev;
   pcie_config_status_bits dut (.*);
   cfg_sw_model host (.rd_o(cfg_rd_i), .wr_o(cfg_wr_i), .addr_o(cfg_dw_addr_i),
      .be_o(cfg_be_i), .wdata_o(cfg_wdata_i), .poison_response_enable_o(poison_response_enable_i),
      .sys_err_report_enable_o(sys_err_report_enable_i));
   always #2.5 ref_clk_i = ~ref_clk_i;
   // Run needs about 2010 cycles
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_status(input logic [15:0] exp);
      chk("status", {16'h0, exp}, {16'h0, link_event_status_o});
   endtask : chk_status
   task automatic tally_and_finish();
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      m = 16'h0000;
      repeat (10) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      chk_status(16'h0010);
      chk("revision", {24'h0, cfg_status_pkg::REVISION_DEFAULT},
          {24'h0, silicon_revision_value_o});
      repeat (2000) begin
         @(negedge ref_clk_i);
         r = $random(seed);
         w = $random(seed);
         ev = r[6:0] & r[13:7];
         host.drive(r[14], r[15], {8'h00, r[17:16]}, r[21:18], w, r[22], r[23]);
         // Expectations use the drawn values, so no port update order is relied on
         clr = (r[15] && r[17:16] == 2'h1) ? w[31:16] & 16'hF900 &
               {{8{r[21]}}, {8{r[20]}}} : 16'h0000;
         set = {ev[0], ev[1] & r[23], ev[2], ev[3], ev[4], 2'h0,
                (ev[5] | ev[6]) & r[22], 8'h00};
         rd = r[14];
         erd = (r[17:16] == 2'h1) ? {m | 16'h0010, 16'h0000} :
               (r[17:16] == 2'h2) ? {24'h0, cfg_status_pkg::REVISION_DEFAULT} : 32'h0;
         m = (m & ~clr) | set;
         @(posedge ref_clk_i);
         #1;
         chk_status(m | 16'h0010);
         chk("rvalid", {31'h0, rd}, {31'h0, cfg_rvalid_o});
         if (rd) chk("rdata", erd, cfg_rdata_o);
      end
      tally_and_finish();
   end
endmodule : pcie_config_status_bits_tb
